// ===== common/hpq_map.svh
// Overview of operation
// - Read-queue-one address register returns the read-data valid flag in its two lowest bits.
// - Bits 15:2 hold the next read address; bits 31:16 read as zero.
// - Low bits show read-data valid: 0 means data waiting, 1 means none.
// - Read-queue control holds enable, flush, drop, not-empty per queue nibble.
// - Read-queue enable bit at 1 holds that queue in reset.
// - Read flush discards pending packets and self-clears when flushing completes.
// - Read flush request is forwarded to the switch-side controller.
// - Read drop-current-packet finishes the current packet, then self-clears.
// - Drop with a second packet queued loses both, flushing the second.
// - Read not-empty bit follows live queue occupancy.
// - Device signals not-empty changes for the status flag; host clears it.
// - Write-queue control holds enable, flush, drop, queue-ready per queue nibble.
// - Write flush at 1 discards written and in-progress packets; 0 does nothing.
// - Write drop at 1 abandons current packet, frees buffers; 0 does nothing.
// - Queue-ready bit mirrors the write-queue status ready flag.
// - Writing write-queue-one address flushes that queue and reloads its address.
`ifndef HPQ_MAP_SVH
`define HPQ_MAP_SVH
`define HPQ_IDX_WQ1_ADDR 8'h1A
`define HPQ_IDX_RQ1_ADDR 8'h1B
`define HPQ_IDX_RQ_CTRL 8'h1C
`define HPQ_IDX_WQ_CTRL 8'h1E
`define HPQ_BIT_EN 3
`define HPQ_BIT_FLUSH 2
`define HPQ_BIT_DROP 1
`define HPQ_BIT_STAT 0
`define HPQ_ADDR_LSB 2
`define HPQ_ADDR_MSB 15
`define HPQ_ADDR_RST 14'h0000
`define HPQ_ADDR_STEP 14'h0001
`define HPQ_DATA_RST 32'h0000_0000
`define HPQ_FIFO_DEPTH 8
`define HPQ_FIFO_WIDTH 32
`define HPQ_BUFFERED_QUEUE 1
`endif

// ===== common/hpq_pkg.sv
package hpq_pkg;
  typedef logic [3:0] hpq_qmask_t;
  typedef enum logic [2:0] {
    HPQ_SEL_NONE,
    HPQ_SEL_WQ1_ADDR,
    HPQ_SEL_RQ1_ADDR,
    HPQ_SEL_RQ_CTRL,
    HPQ_SEL_WQ_CTRL
  } hpq_sel_t;
endpackage

// ===== sim/hpq_sw_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Switch-side controller model: answers each held request with one done pulse.
module hpq_sw_model #(
  parameter int LAT = 2
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Answer speed.
  input wire logic slow_i,
  // Requests and completions.
  input wire logic [3:0] req_i,
  output logic [3:0] done_o
);
  int cnt [4];
  initial done_o = 4'h0;
  always @(negedge core_clk_i or posedge sys_rst_i) begin
    for (int i = 0; i < 4; i++) begin
      if (sys_rst_i || !req_i[i]) begin
        cnt[i] = 0;
        done_o[i] <= 1'b0;
      end else begin
        done_o[i] <= (cnt[i] == (slow_i ? 4 * LAT : LAT));
        if (cnt[i] <= 4 * LAT) cnt[i] = cnt[i] + 1;
      end
    end
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] host_addr_i = 8'h00;
  logic host_wr_i = 1'b0;
  logic host_rd_i = 1'b0;
  logic host_qrd_i = 1'b0;
  logic sw_rq_valid_i = 1'b0;
  logic slow = 1'b0;
  logic acc, seen, sw_rq_ready_o, wq1_addr_load_o;
  logic [31:0] host_wdata_i = 32'h0000_0000;
  logic [31:0] sw_rq_data_i = 32'h0000_0000;
  logic [31:0] host_rdata_o, host_qdata_o, rd, last;
  logic [3:0] rq_occupied_i = 4'h0;
  logic [3:0] wq_ready_i = 4'h0;
  logic [3:0] occ = 4'h0;
  logic [3:0] rq_flush_done_i, rq_drop_done_i, wq_flush_done_i, wq_drop_done_i;
  logic [3:0] rq_hold_o, rq_flush_o, rq_drop_o, rq_ne_change_o, wq_hold_o, wq_flush_o, wq_drop_o;
  logic [13:0] wq1_addr_o;
  logic [7:0] lfsr = 8'h5E;
  logic [7:0] a;
  logic [31:0] mq [$];
  int fail_count = 0;
  int cmp_count = 0;
  int maddr = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  always #20 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) rq_occupied_i <= {occ[3:2], mq.size() != 0, occ[0]};
  hpq_ctrl dut_u (.core_clk_i, .sys_rst_i, .host_addr_i, .host_wr_i, .host_rd_i, .host_wdata_i, .host_rdata_o,
    .host_qrd_i, .host_qdata_o, .sw_rq_valid_i, .sw_rq_ready_o, .sw_rq_data_i, .rq_occupied_i, .rq_flush_done_i,
    .rq_drop_done_i, .rq_hold_o, .rq_flush_o, .rq_drop_o, .rq_ne_change_o, .wq_ready_i, .wq_flush_done_i,
    .wq_drop_done_i, .wq_hold_o, .wq_flush_o, .wq_drop_o, .wq1_addr_load_o, .wq1_addr_o);
  hpq_sw_model rf_u (.core_clk_i, .sys_rst_i, .slow_i(slow), .req_i(rq_flush_o), .done_o(rq_flush_done_i));
  hpq_sw_model rd_u (.core_clk_i, .sys_rst_i, .slow_i(slow), .req_i(rq_drop_o), .done_o(rq_drop_done_i));
  hpq_sw_model wf_u (.core_clk_i, .sys_rst_i, .slow_i(slow), .req_i(wq_flush_o), .done_o(wq_flush_done_i));
  hpq_sw_model wd_u (.core_clk_i, .sys_rst_i, .slow_i(slow), .req_i(wq_drop_o), .done_o(wq_drop_done_i));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] exp_addr();
    return {16'h0000, 14'(maddr), {2{mq.size() == 0}}};
  endfunction
  function automatic logic [31:0] exp_ctrl(logic [3:0] st);
    logic [31:0] e;
    e = 32'h0000_0000;
    for (int q = 0; q < 4; q++) e[4*q] = st[q];
    return e;
  endfunction
  function automatic logic [3:0] req_vec(int s, int b);
    return s ? (b == 2 ? wq_flush_o : wq_drop_o) : (b == 2 ? rq_flush_o : rq_drop_o);
  endfunction
  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
    @(negedge core_clk_i);
    host_addr_i = ad;
    host_wdata_i = d;
    host_wr_i = 1'b1;
    @(negedge core_clk_i);
    host_wr_i = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] ad);
    @(negedge core_clk_i);
    host_addr_i = ad;
    host_rd_i = 1'b1;
    @(negedge core_clk_i);
    host_rd_i = 1'b0;
    rd = host_rdata_o;
  endtask
  task automatic chk_addr();
    reg_rd(8'h1B);
    `CHK(rd, exp_addr())
  endtask
  task automatic push();
    @(negedge core_clk_i);
    lfsr = lfsr_next(lfsr);
    sw_rq_data_i = {lfsr, 8'hA5, ~lfsr, 8'(mq.size())};
    sw_rq_valid_i = 1'b1;
    acc = sw_rq_ready_o;
    @(negedge core_clk_i);
    sw_rq_valid_i = 1'b0;
    if (acc) mq.push_back(sw_rq_data_i);
  endtask
  task automatic pop();
    @(negedge core_clk_i);
    host_qrd_i = 1'b1;
    @(negedge core_clk_i);
    host_qrd_i = 1'b0;
    if (mq.size() != 0) begin
      last = mq.pop_front();
      maddr = (maddr + 1) % 16384;
    end
    `CHK(host_qdata_o, last)
  endtask
  task automatic wait_idle(int s, int b);
    n = 0;
    while (req_vec(s, b) !== 4'h0 && n < 60) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    chk_addr();
    reg_rd(8'h1D);
    `CHK(rd, 32'h0000_0000)
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      occ = lfsr[3:0];
      wq_ready_i = lfsr[7:4];
      reg_rd(8'h1C);
      `CHK(rd, exp_ctrl({occ[3:2], 1'b0, occ[0]}))
      reg_rd(8'h1E);
      `CHK(rd, exp_ctrl(wq_ready_i))
    end
    occ[0] = ~occ[0];
    seen = 1'b0;
    repeat (6) begin
      @(negedge core_clk_i);
      seen = seen | rq_ne_change_o[0];
    end
    `CHK(seen, 1'b1)
    reg_wr(8'h1B, 32'hFFFF_FFFF);
    maddr = 16383;
    chk_addr();
    for (int i = 0; i < 9; i++) begin
      push();
      `CHK(acc, i < 8)
    end
    chk_addr();
    reg_rd(8'h1C);
    `CHK(rd[4], 1'b1)
    repeat (9) pop();
    chk_addr();
    for (int s = 0; s < 2; s++) begin
      a = s ? 8'h1E : 8'h1C;
      reg_wr(a, 32'h0000_00C0);
      `CHK({s ? wq_hold_o : rq_hold_o, req_vec(s, 2), sw_rq_ready_o ^ s[0]}, 9'h040)
      reg_rd(a);
      `CHK(rd[7:4], {3'b100, s[0] & wq_ready_i[1]})
      reg_wr(a, 32'h0000_0000);
      `CHK({req_vec(s, 1), req_vec(s, 2), s ? wq_hold_o : rq_hold_o}, 12'h000)
    end
    push();
    push();
    for (int s = 0; s < 2; s++) begin
      for (int b = 1; b < 3; b++) begin
        for (int q = 0; q < 4; q++) begin
          a = s ? 8'h1E : 8'h1C;
          slow = q[0];
          reg_wr(a, 32'h0000_0001 << (4 * q + b));
          `CHK(req_vec(s, b), 4'h1 << q)
          if (s == 0 && q == 1) mq.delete();
          if (slow) begin
            reg_rd(a);
            `CHK(rd[4*q+b], 1'b1)
          end
          wait_idle(s, b);
          reg_rd(a);
          `CHK(rd[4*q+b], 1'b0)
          if (s == 0 && b == 1 && q == 1) begin
            reg_rd(8'h1B);
            `CHK(rd[1:0], 2'b11)
          end
        end
      end
    end
    reg_wr(8'h1C, 32'h0000_0006);
    `CHK({rq_flush_o[0], rq_drop_o[0]}, 2'b10)
    wait_idle(0, 2);
    reg_rd(8'h1C);
    `CHK(rd[2:1], 2'b00)
    reg_wr(8'h1A, 32'h0000_1234);
    `CHK({wq1_addr_load_o, wq1_addr_o, wq_flush_o[1]}, {1'b1, 14'h048D, 1'b1})
    reg_rd(8'h1A);
    `CHK(rd, 32'h0000_1234)
    wait_idle(1, 2);
    `CHK(wq_flush_o, 4'h0)
    complete_run();
  end
endmodule

// ===== src/hpq_ctrl.sv
`timescale 1ns/1ps
`include "hpq_map.svh"
module hpq_ctrl
  import hpq_pkg::*;
#(
  parameter int NUM_QUEUES = 4,
  parameter int FIFO_DEPTH = `HPQ_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Host register port.
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [31:0] host_wdata_i,
  output logic [31:0] host_rdata_o,
  // Host queue data read.
  input wire logic host_qrd_i,
  output logic [31:0] host_qdata_o,
  // Switch-side read queue one data feed.
  input wire logic sw_rq_valid_i,
  output logic sw_rq_ready_o,
  input wire logic [31:0] sw_rq_data_i,
  // Switch-side read queue control.
  input wire logic [3:0] rq_occupied_i,
  input wire logic [3:0] rq_flush_done_i,
  input wire logic [3:0] rq_drop_done_i,
  output logic [3:0] rq_hold_o,
  output logic [3:0] rq_flush_o,
  output logic [3:0] rq_drop_o,
  output logic [3:0] rq_ne_change_o,
  // Switch-side write queue control.
  input wire logic [3:0] wq_ready_i,
  input wire logic [3:0] wq_flush_done_i,
  input wire logic [3:0] wq_drop_done_i,
  output logic [3:0] wq_hold_o,
  output logic [3:0] wq_flush_o,
  output logic [3:0] wq_drop_o,
  output logic wq1_addr_load_o,
  output logic [13:0] wq1_addr_o
);
  if (NUM_QUEUES != 4 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("hpq_ctrl serves exactly four queues and a FIFO of at least two words");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  hpq_sel_t sel;
  hpq_qmask_t rq_en_reg;
  hpq_qmask_t rq_flush_reg;
  hpq_qmask_t rq_drop_reg;
  hpq_qmask_t wq_en_reg;
  hpq_qmask_t wq_flush_reg;
  hpq_qmask_t wq_drop_reg;
  hpq_qmask_t rq_hold;
  hpq_qmask_t wq_hold;
  hpq_qmask_t rq_ne;
  hpq_qmask_t rq_ne_prev_reg;
  logic [13:0] rq1_addr_reg;
  logic [31:0] rdata_next;
  logic rq_ctrl_wr;
  logic wq_ctrl_wr;
  logic wq1_addr_wr;
  logic fifo_clr;
  logic fifo_valid;
  logic [31:0] fifo_data;
  logic qpop;

  always_comb begin
    case (host_addr_i)
      `HPQ_IDX_WQ1_ADDR: sel = HPQ_SEL_WQ1_ADDR;
      `HPQ_IDX_RQ1_ADDR: sel = HPQ_SEL_RQ1_ADDR;
      `HPQ_IDX_RQ_CTRL: sel = HPQ_SEL_RQ_CTRL;
      `HPQ_IDX_WQ_CTRL: sel = HPQ_SEL_WQ_CTRL;
      default: sel = HPQ_SEL_NONE;
    endcase
  end

  assign rq_ctrl_wr = host_wr_i && (sel == HPQ_SEL_RQ_CTRL);
  assign wq_ctrl_wr = host_wr_i && (sel == HPQ_SEL_WQ_CTRL);
  assign wq1_addr_wr = host_wr_i && (sel == HPQ_SEL_WQ1_ADDR);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-queue control bits.
  for (genvar k = 0; k < 4; k++) begin : g_queue
    // A queue is held while its enable bit is 1, including the cycle it is written.
    assign rq_hold[k] = rq_en_reg[k] || (rq_ctrl_wr && host_wdata_i[4*k+`HPQ_BIT_EN]);
    assign wq_hold[k] = wq_en_reg[k] || (wq_ctrl_wr && host_wdata_i[4*k+`HPQ_BIT_EN]);

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        rq_en_reg[k] <= 1'b0;
        wq_en_reg[k] <= 1'b0;
      end else begin
        if (rq_ctrl_wr) begin
          rq_en_reg[k] <= host_wdata_i[4*k+`HPQ_BIT_EN];
        end
        if (wq_ctrl_wr) begin
          wq_en_reg[k] <= host_wdata_i[4*k+`HPQ_BIT_EN];
        end
      end
    end

    // Read flush: a host set wins over the completion clear.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        rq_flush_reg[k] <= 1'b0;
      end else if (rq_hold[k]) begin
        rq_flush_reg[k] <= 1'b0;
      end else if (rq_ctrl_wr && host_wdata_i[4*k+`HPQ_BIT_FLUSH]) begin
        rq_flush_reg[k] <= 1'b1;
      end else if (rq_flush_done_i[k]) begin
        rq_flush_reg[k] <= 1'b0;
      end
    end

    // Read drop: ends with its own completion, or with a pending flush.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        rq_drop_reg[k] <= 1'b0;
      end else if (rq_hold[k]) begin
        rq_drop_reg[k] <= 1'b0;
      end else if (rq_ctrl_wr && host_wdata_i[4*k+`HPQ_BIT_DROP]) begin
        rq_drop_reg[k] <= 1'b1;
      end else if (rq_flush_reg[k] ? rq_flush_done_i[k] : rq_drop_done_i[k]) begin
        rq_drop_reg[k] <= 1'b0;
      end
    end

    // Write flush: also started by a write of the queue-one address.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        wq_flush_reg[k] <= 1'b0;
      end else if (wq_hold[k]) begin
        wq_flush_reg[k] <= 1'b0;
      end else if ((wq_ctrl_wr && host_wdata_i[4*k+`HPQ_BIT_FLUSH]) || (wq1_addr_wr && k == 1)) begin
        wq_flush_reg[k] <= 1'b1;
      end else if (wq_flush_done_i[k]) begin
        wq_flush_reg[k] <= 1'b0;
      end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        wq_drop_reg[k] <= 1'b0;
      end else if (wq_hold[k]) begin
        wq_drop_reg[k] <= 1'b0;
      end else if (wq_ctrl_wr && host_wdata_i[4*k+`HPQ_BIT_DROP]) begin
        wq_drop_reg[k] <= 1'b1;
      end else if (wq_flush_reg[k] ? wq_flush_done_i[k] : wq_drop_done_i[k]) begin
        wq_drop_reg[k] <= 1'b0;
      end
    end
  end

  // A drop waits while a whole-queue flush is pending for the same queue.
  assign rq_hold_o = rq_en_reg;
  assign rq_flush_o = rq_flush_reg;
  assign rq_drop_o = rq_drop_reg & ~rq_flush_reg;
  assign wq_hold_o = wq_en_reg;
  assign wq_flush_o = wq_flush_reg;
  assign wq_drop_o = wq_drop_reg & ~wq_flush_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Read queue one data buffer.
  // A queue-one read drop empties the whole buffer, so a following queued packet is lost too.
  assign fifo_clr = rq_en_reg[`HPQ_BUFFERED_QUEUE] || rq_flush_reg[`HPQ_BUFFERED_QUEUE]
                    || rq_drop_reg[`HPQ_BUFFERED_QUEUE];
  assign qpop = host_qrd_i && fifo_valid;

  hpq_fifo #(
    .WIDTH(`HPQ_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(fifo_clr),
    .in_valid_i(sw_rq_valid_i),
    .in_ready_o(sw_rq_ready_o),
    .in_data_i(sw_rq_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(host_qrd_i),
    .out_data_o(fifo_data)
  );

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_qdata_o <= `HPQ_DATA_RST;
    end else if (qpop) begin
      host_qdata_o <= fifo_data;
    end
  end

  // Long-word read address; advances one word per popped entry.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rq1_addr_reg <= `HPQ_ADDR_RST;
    end else if (rq_en_reg[`HPQ_BUFFERED_QUEUE]) begin
      rq1_addr_reg <= `HPQ_ADDR_RST;
    end else if (host_wr_i && sel == HPQ_SEL_RQ1_ADDR) begin
      rq1_addr_reg <= host_wdata_i[`HPQ_ADDR_MSB:`HPQ_ADDR_LSB];
    end else if (qpop) begin
      rq1_addr_reg <= rq1_addr_reg + `HPQ_ADDR_STEP;
    end
  end

  // Write queue one address; the load also flushes that queue.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wq1_addr_o <= `HPQ_ADDR_RST;
      wq1_addr_load_o <= 1'b0;
    end else begin
      wq1_addr_load_o <= wq1_addr_wr;
      if (wq1_addr_wr) begin
        wq1_addr_o <= host_wdata_i[`HPQ_ADDR_MSB:`HPQ_ADDR_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Occupancy and change reporting.
  always_comb begin
    rq_ne = rq_occupied_i & ~rq_en_reg;
    rq_ne[`HPQ_BUFFERED_QUEUE] = rq_ne[`HPQ_BUFFERED_QUEUE] || fifo_valid;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rq_ne_prev_reg <= '0;
      rq_ne_change_o <= '0;
    end else begin
      rq_ne_prev_reg <= rq_ne;
      rq_ne_change_o <= rq_ne ^ rq_ne_prev_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.
  always_comb begin
    rdata_next = `HPQ_DATA_RST;
    case (sel)
      HPQ_SEL_WQ1_ADDR: rdata_next[`HPQ_ADDR_MSB:`HPQ_ADDR_LSB] = wq1_addr_o;
      HPQ_SEL_RQ1_ADDR: begin
        rdata_next[`HPQ_ADDR_MSB:`HPQ_ADDR_LSB] = rq1_addr_reg;
        rdata_next[1:0] = {2{!fifo_valid}};
      end
      HPQ_SEL_RQ_CTRL: begin
        for (int k = 0; k < 4; k++) begin
          rdata_next[4*k +: 4] = {rq_en_reg[k], rq_flush_reg[k], rq_drop_reg[k], rq_ne[k]};
        end
      end
      HPQ_SEL_WQ_CTRL: begin
        for (int k = 0; k < 4; k++) begin
          rdata_next[4*k +: 4] = {wq_en_reg[k], wq_flush_reg[k], wq_drop_reg[k], wq_ready_i[k]};
        end
      end
      default: rdata_next = `HPQ_DATA_RST;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_rdata_o <= `HPQ_DATA_RST;
    end else if (host_rd_i) begin
      host_rdata_o <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_rq1_reserved;
    host_rd_i && sel == HPQ_SEL_RQ1_ADDR |=> host_rdata_o[31:16] == 16'h0000;
  endproperty
  a_rq1_reserved: assert property (p_rq1_reserved) else $error("reserved bits not zero");

  property p_rq1_valid;
    host_rd_i && sel == HPQ_SEL_RQ1_ADDR |=> host_rdata_o[1:0] == {2{!$past(fifo_valid)}};
  endproperty
  a_rq1_valid: assert property (p_rq1_valid) else $error("valid flag wrong");

  property p_hold_clears;
    rq_en_reg[0] |-> !rq_flush_reg[0] && !rq_drop_reg[0];
  endproperty
  a_hold_clears: assert property (p_hold_clears) else $error("held queue has pending request");

  property p_rq_flush_fwd;
    rq_ctrl_wr && host_wdata_i[2] && !rq_hold[0] |=> rq_flush_o[0];
  endproperty
  a_rq_flush_fwd: assert property (p_rq_flush_fwd) else $error("flush not forwarded");

  property p_rq_flush_done;
    rq_flush_reg[0] && rq_flush_done_i[0] && !rq_ctrl_wr && !rq_en_reg[0] |=> !rq_flush_reg[0] && !rq_drop_reg[0];
  endproperty
  a_rq_flush_done: assert property (p_rq_flush_done) else $error("flush did not self-clear");

  property p_rq_drop_fwd;
    rq_ctrl_wr && host_wdata_i[1] && !host_wdata_i[2] && !rq_hold[0] && !rq_flush_reg[0] |=> rq_drop_o[0];
  endproperty
  a_rq_drop_fwd: assert property (p_rq_drop_fwd) else $error("read drop not raised");

  property p_both_written;
    rq_ctrl_wr && host_wdata_i[2] && host_wdata_i[1] && !rq_hold[0] |=> rq_flush_o[0] && !rq_drop_o[0] && rq_drop_reg[0];
  endproperty
  a_both_written: assert property (p_both_written) else $error("drop not withheld behind flush");

  property p_rq1_held;
    rq_en_reg[1] |-> !sw_rq_ready_o && !fifo_valid && !rq_ne[1];
  endproperty
  a_rq1_held: assert property (p_rq1_held) else $error("held queue still active");

  property p_ne_change;
    rq_ne[0] != $past(rq_ne[0]) |=> rq_ne_change_o[0];
  endproperty
  a_ne_change: assert property (p_ne_change) else $error("not-empty change not reported");

  property p_drop_empties;
    rq_drop_o[1] |=> !fifo_valid;
  endproperty
  a_drop_empties: assert property (p_drop_empties) else $error("drop left data");

  property p_ne_live;
    host_rd_i && sel == HPQ_SEL_RQ_CTRL && !rq_en_reg[1] |=> host_rdata_o[4] == $past(fifo_valid || rq_occupied_i[1]);
  endproperty
  a_ne_live: assert property (p_ne_live) else $error("not-empty bit stale");

  property p_wq_flush;
    wq_ctrl_wr && host_wdata_i[6] && !wq_hold[1] |=> wq_flush_o[1] ##0 !wq_drop_o[1] || !$past(wq_drop_reg[1]);
  endproperty
  a_wq_flush: assert property (p_wq_flush) else $error("write flush not raised");

  property p_wq_drop;
    wq_ctrl_wr && host_wdata_i[1] && !wq_hold[0] && !wq_flush_reg[0] && !host_wdata_i[2] |=> wq_drop_o[0];
  endproperty
  a_wq_drop: assert property (p_wq_drop) else $error("write drop not raised");

  property p_ready_mirror;
    host_rd_i && sel == HPQ_SEL_WQ_CTRL |=> host_rdata_o[0] == $past(wq_ready_i[0]);
  endproperty
  a_ready_mirror: assert property (p_ready_mirror) else $error("queue-ready not mirrored");

  property p_wq1_addr;
    wq1_addr_wr && !wq_hold[1] |=> wq1_addr_load_o && wq_flush_o[1] && wq1_addr_o == $past(host_wdata_i[15:2]);
  endproperty
  a_wq1_addr: assert property (p_wq1_addr) else $error("address write did not flush");
endmodule

// ===== src/hpq_fifo.sv
`timescale 1ns/1ps
module hpq_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  // Filling side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("hpq_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH)) && !clr_i;
  assign out_valid_o = (count_reg != '0) && !clr_i;
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage write.
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clr_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
